// ===== shared/burst_drive_regs.vh
// Register map, field positions and reset values of the burst drive register slice
`ifndef BURST_DRIVE_REGS_VH
`define BURST_DRIVE_REGS_VH

// ==================================================
// Register addresses (7-bit register space)
`define ADDR_BURST_DRIVE_CONFIG 7'h1a
`define ADDR_POWER_AND_TRIGGER 7'h1b
`define ADDR_FAULT_AND_SUPPLY 7'h1c
`define ADDR_PART_IDENT 7'h1d
`define ADDR_SILICON_REV 7'h1e
`define ADDR_DRIVE_SUPPLY_CTRL 7'h16
`define ADDR_IO_CONFIG 7'h14

// ==================================================
// Field positions
`define BIT_PAIRED_SIDE 7
`define BIT_PRE_DRIVER 6
`define PULSE_COUNT_HI 5
`define BIT_SLEEP 7
`define BIT_STANDBY 6
`define BIT_SUPPLY_TRIG 1
`define BIT_CMD_TRIG 0
`define BIT_SUPPLY_READY 3
`define BIT_PULSE_FAULT 2
`define BIT_STUCK_FAULT 1
`define BIT_NVM_FAULT 0
`define BIT_AUTO_OFF 6
`define BIT_FLOAT 5
`define IO_MODE_HI 1
`define DEGLITCH_HI 4
`define DEGLITCH_LO 2

// ==================================================
// Masks and reset values
`define MASK_BURST_CFG 8'hff
`define MASK_POWER_TRIG 8'hc3
`define MASK_SUPPLY_CTRL 8'h7f
`define MASK_IO_CONFIG 8'h1f
`define RESET_BURST_CFG 8'h00
`define RESET_POWER_TRIG 8'h00
`define RESET_SUPPLY_CTRL 8'h20
`define RESET_IO_CONFIG 8'h00
`define IO_MODE_REGISTER 2'h0
`define DEGLITCH_OFF 3'h7
`define ZERO_COUNT 6'h00
`define ZERO_BYTE 8'h00

// ==================================================
// SPI frame layout: 16 bits, MSB first, bit 15 = read, 14:8 = address, 7:0 = data
`define FRAME_BITS 5'h10
`define FRAME_LAST 5'h0f
`define FRAME_ADDR_END 5'h08

`endif

// ===== hw/stuck_watch.v
// Watches the drive pin for a state held longer than the deglitch window
`timescale 1ns/1ps
`default_nettype none
`include "burst_drive_regs.vh"

module stuck_watch (
  input wire clock,
  input wire resetn,
  input wire active,
  input wire drive_level,
  input wire [2:0] deglitch_sel,
  output reg stuck
);

  // Deglitch code to cycle limit at 25 MHz; code 7 disables the check
  reg [11:0] limit;
  always @* begin
    case (deglitch_sel)
      3'h0: limit = 12'h0c80;
      3'h1: limit = 12'h0640;
      3'h2: limit = 12'h0320;
      3'h3: limit = 12'h0190;
      3'h4: limit = 12'h00c8;
      3'h5: limit = 12'h00c8;
      3'h6: limit = 12'h0064;
      default: limit = 12'h0fff;
    endcase
  end

  reg [11:0] held;
  reg last_level;

  // Count cycles without a level change while bursting
  always @(posedge clock) begin
    if (!resetn) begin
      held <= 12'h0000;
      last_level <= 1'b0;
      stuck <= 1'b0;
    end else begin
      last_level <= drive_level;
      if (!active || drive_level != last_level) begin
        held <= 12'h0000;
      end else if (held != 12'h0fff) begin
        held <= held + 12'h0001;
      end
      if (active && deglitch_sel != `DEGLITCH_OFF && held >= limit) begin
        stuck <= 1'b1;
      end else if (!active) begin
        stuck <= 1'b0;
      end
    end
  end

endmodule // stuck_watch
`default_nettype wire

// ===== hw/burst_drive_control_status.v
// Burst drive configuration, power control and status registers behind an SPI target port
//
// Summary of operation
// - Paired-side select drives both high sides together and both low sides together.
// - Pre-driver select runs the stage as pre-driver for external transistors.
// - Six-bit pulse count per burst; zero means continuous bursting.
// - Sleep request bit one enters sleep, zero wakes.
// - Standby request bit one enters standby, zero leaves it.
// - With auto-off enabled, supply charge trigger gates the charge current.
// - Supply charge trigger has no effect while the supply floats.
// - In IO mode zero the command trigger starts and stops bursts.
// - In other IO modes the command trigger is ignored.
// - Read-only supply-ready flag shows supply at or above regulation.
// - Pulse-count fault set when fewer pulses arrive than programmed.
// - Stuck-driver fault when the driver holds one state past deglitch time.
// - Fault flag set when the memory check fails.
// - Auto-off turns charging off at burst end when the trigger is zero.
// - Two-bit IO mode field selects one of three burst sources; codes one and three both use inverted pin 1.
// - Float bit stops the supply current source and regulation.
`timescale 1ns/1ps
`default_nettype none
`include "burst_drive_regs.vh"

module burst_drive_control_status #(
  parameter [7:0] PART_IDENT_VALUE = 8'h5a, // Arbitrary identity value
  parameter [7:0] SILICON_REV_VALUE = 8'h01 // Arbitrary revision value
) (
  input wire clock,
  input wire resetn,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  input wire burst_pin_1,
  input wire burst_pin_2,
  input wire drive_pulse_in,
  input wire supply_at_level,
  input wire nvm_check_failed,
  output reg paired_side_drive_select,
  output reg pre_driver_enable,
  output reg [5:0] pulse_count,
  output reg sleep_active,
  output reg standby_active,
  output reg burst_active,
  output reg charge_enable,
  output reg regulation_enable
);

  // ==================================================
  // Input synchronisers (two flops each)
  reg [5:0] sync_a;
  reg [5:0] sync_b;
  always @(posedge clock) begin
    if (!resetn) begin
      sync_a <= 6'h3c;
      sync_b <= 6'h3c;
    end else begin
      sync_a <= {spi_cs_n, spi_sclk, spi_mosi, burst_pin_1, burst_pin_2, drive_pulse_in};
      sync_b <= sync_a;
    end
  end
  wire cs_n_s = sync_b[5];
  wire sclk_s = sync_b[4];
  wire mosi_s = sync_b[3];
  wire pin1_s = sync_b[2];
  wire pin2_s = sync_b[1];
  wire pulse_s = sync_b[0];

  reg [1:0] flag_a;
  reg [1:0] flag_b;
  always @(posedge clock) begin
    if (!resetn) begin
      flag_a <= 2'h0;
      flag_b <= 2'h0;
    end else begin
      flag_a <= {supply_at_level, nvm_check_failed};
      flag_b <= flag_a;
    end
  end

  // SCLK edge detection on the synchronised copy
  reg sclk_d;
  always @(posedge clock) begin
    if (!resetn) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;

  // ==================================================
  // Registers
  reg [7:0] burst_cfg;
  reg [7:0] power_trig;
  reg [7:0] supply_ctrl;
  reg [7:0] io_config;
  reg pulse_fault;
  wire stuck_fault;

  wire [1:0] io_mode = io_config[`IO_MODE_HI:0];
  wire auto_off = supply_ctrl[`BIT_AUTO_OFF];
  wire supply_float = supply_ctrl[`BIT_FLOAT];

  // Status byte; upper bits reserved and read zero
  wire [7:0] status_byte = {4'h0, flag_b[1], pulse_fault, stuck_fault, flag_b[0]};

  // ==================================================
  // SPI target: 16-bit frames, mode 1 (shift out on rise, sample on fall)
  reg [4:0] bit_count;
  reg [15:0] shift_in;
  reg [7:0] shift_out;
  reg write_pending;

  wire [15:0] next_shift_in = {shift_in[14:0], mosi_s};
  wire [6:0] frame_addr = next_shift_in[6:0];

  // Read mux, reserved and unmapped return zero
  reg [7:0] read_data;
  always @* begin
    case (frame_addr)
      `ADDR_BURST_DRIVE_CONFIG: read_data = burst_cfg;
      `ADDR_POWER_AND_TRIGGER: read_data = power_trig & `MASK_POWER_TRIG;
      `ADDR_FAULT_AND_SUPPLY: read_data = status_byte;
      `ADDR_PART_IDENT: read_data = PART_IDENT_VALUE;
      `ADDR_SILICON_REV: read_data = SILICON_REV_VALUE;
      `ADDR_DRIVE_SUPPLY_CTRL: read_data = supply_ctrl;
      `ADDR_IO_CONFIG: read_data = io_config;
      default: read_data = `ZERO_BYTE;
    endcase
  end

  // Frame shifter; registers are written only through this port
  always @(posedge clock) begin
    if (!resetn) begin
      bit_count <= 5'h00;
      shift_in <= 16'h0000;
      shift_out <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
      write_pending <= 1'b0;
      burst_cfg <= `RESET_BURST_CFG;
      power_trig <= `RESET_POWER_TRIG;
      supply_ctrl <= `RESET_SUPPLY_CTRL;
      io_config <= `RESET_IO_CONFIG;
    end else begin
      spi_miso_oe <= ~cs_n_s;
      if (cs_n_s) begin
        bit_count <= 5'h00;
        write_pending <= 1'b0;
      end else begin
        if (sclk_rise) begin
          spi_miso <= shift_out[7];
          shift_out <= {shift_out[6:0], 1'b0};
        end
        if (sclk_fall) begin
          shift_in <= next_shift_in;
          bit_count <= bit_count + 5'h01;
          // Address complete: latch read data for the second byte
          if (bit_count == `FRAME_ADDR_END - 5'h01) begin
            shift_out <= read_data;
            write_pending <= ~next_shift_in[7];
          end
          // Frame complete: commit write, masking reserved and read-only
          if (bit_count == `FRAME_LAST && write_pending) begin
            case (next_shift_in[14:8])
              `ADDR_BURST_DRIVE_CONFIG: burst_cfg <= next_shift_in[7:0] & `MASK_BURST_CFG;
              `ADDR_POWER_AND_TRIGGER: power_trig <= next_shift_in[7:0] & `MASK_POWER_TRIG;
              `ADDR_DRIVE_SUPPLY_CTRL: supply_ctrl <= next_shift_in[7:0] & `MASK_SUPPLY_CTRL;
              `ADDR_IO_CONFIG: io_config <= next_shift_in[7:0] & `MASK_IO_CONFIG;
              default: write_pending <= 1'b0;
            endcase
          end
          if (bit_count == `FRAME_LAST) begin
            bit_count <= 5'h00;
          end
        end
      end
    end
  end

  // ==================================================
  // Burst request source by IO mode
  reg burst_request;
  always @* begin
    case (io_mode)
      `IO_MODE_REGISTER: burst_request = power_trig[`BIT_CMD_TRIG];
      2'h2: burst_request = pin1_s ^ pin2_s;
      default: burst_request = ~pin1_s;
    endcase
  end

  // Pulse counting within a burst
  reg [5:0] pulses_seen;
  reg pulse_d;
  wire pulse_edge = pulse_s & ~pulse_d;
  wire burst_end = burst_active & ~burst_request;
  wire [5:0] programmed = burst_cfg[`PULSE_COUNT_HI:0];

  // Burst state, pulse count and pulse fault
  always @(posedge clock) begin
    if (!resetn) begin
      burst_active <= 1'b0;
      pulses_seen <= `ZERO_COUNT;
      pulse_d <= 1'b0;
      pulse_fault <= 1'b0;
    end else begin
      pulse_d <= pulse_s;
      burst_active <= burst_request & ~sleep_active;
      if (!burst_active) begin
        pulses_seen <= `ZERO_COUNT;
      end else if (pulse_edge && pulses_seen != 6'h3f) begin
        pulses_seen <= pulses_seen + 6'h01;
      end
      // Continuous bursts (count zero) have no pulse limit
      if (burst_end && programmed != `ZERO_COUNT) begin
        pulse_fault <= (pulses_seen < programmed);
      end
    end
  end

  stuck_watch u_stuck_watch (
    .clock(clock),
    .resetn(resetn),
    .active(burst_active),
    .drive_level(pulse_s),
    .deglitch_sel(io_config[`DEGLITCH_HI:`DEGLITCH_LO]),
    .stuck(stuck_fault)
  );

  // ==================================================
  // Charge gating for the drive supply; listen phase starts with charging off
  // so that the trigger alone decides it outside bursts, except the first cycle after sleep ends a burst
  reg listen_off;
  always @(posedge clock) begin
    if (!resetn) begin
      listen_off <= 1'b1;
    end else if (burst_active && !burst_end) begin
      listen_off <= 1'b0;
    end else begin
      listen_off <= 1'b1;
    end
  end

  // Control outputs, all registered
  always @(posedge clock) begin
    if (!resetn) begin
      paired_side_drive_select <= 1'b0;
      pre_driver_enable <= 1'b0;
      pulse_count <= `ZERO_COUNT;
      sleep_active <= 1'b0;
      standby_active <= 1'b0;
      charge_enable <= 1'b0;
      regulation_enable <= 1'b0;
    end else begin
      paired_side_drive_select <= burst_cfg[`BIT_PAIRED_SIDE];
      pre_driver_enable <= burst_cfg[`BIT_PRE_DRIVER];
      pulse_count <= programmed;
      sleep_active <= power_trig[`BIT_SLEEP];
      standby_active <= power_trig[`BIT_STANDBY];
      regulation_enable <= ~supply_float;
      if (supply_float) begin
        charge_enable <= 1'b0;
      end else if (auto_off && !burst_active) begin
        charge_enable <= power_trig[`BIT_SUPPLY_TRIG] | ~listen_off;
      end else begin
        charge_enable <= 1'b1;
      end
    end
  end

endmodule // burst_drive_control_status
`default_nettype wire

// ===== sim/spi_ctrl_model.sv
// SPI controller model that runs mode-1 frames into the register slice
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_model (
  input wire logic clock,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // ==========================================
  // Idle levels
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One 16-bit frame, MSB first, clock idles low between frames
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    @(posedge clock) cs_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b1;
      mosi <= f[i];
      repeat (4) @(posedge clock);
      sclk <= 1'b0;
      repeat (4) @(posedge clock);
      if (i < 8) rd[i] = miso; // Taken late in the low phase, well after the shift
    end
    cs_n <= 1'b1;
    mosi <= ~mosi; // Released line shows no stale value
    repeat (6) @(posedge clock);
  endtask
endmodule // spi_ctrl_model
`default_nettype wire

// ===== sim/bdcs_properties.sv
// Concurrent checks on the ports of the burst drive register slice
`timescale 1ns/1ps
`default_nettype none
module bdcs_properties (
  input wire clock,
  input wire resetn,
  input wire spi_cs_n,
  input wire spi_miso_oe,
  input wire paired_side_drive_select,
  input wire pre_driver_enable,
  input wire [5:0] pulse_count,
  input wire sleep_active,
  input wire standby_active,
  input wire burst_active,
  input wire charge_enable,
  input wire regulation_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  int idle_count;
  // Counts cycles since chip select was last low
  always @(posedge clock) begin
    if (!resetn || !spi_cs_n) idle_count <= 0;
    else if (idle_count < 100) idle_count <= idle_count + 1;
  end
  // ==========================================
  // Sequences and assertions
  sequence bus_idle; spi_cs_n [*6]; endsequence
  sequence sleep_held; sleep_active [*3]; endsequence
  a_reset_quiet: assert property ($rose(resetn) |-> !(burst_active | charge_enable | sleep_active | (|pulse_count)))
    else $error("outputs not cleared by reset");
  a_config_frame_only: assert property (!$stable({paired_side_drive_select, pre_driver_enable, pulse_count}) |-> idle_count < 8)
    else $error("drive config changed outside a frame");
  a_power_frame_only: assert property ($changed({sleep_active, standby_active, regulation_enable}) |-> idle_count < 8)
    else $error("power control changed outside a frame");
  a_sleep_no_burst: assert property (sleep_held |-> !burst_active)
    else $error("burst while asleep");
  a_float_no_charge: assert property (!regulation_enable [*2] |-> !charge_enable)
    else $error("charging while supply floats");
  a_burst_charge_on: assert property ((burst_active && regulation_enable) [*2] |-> charge_enable)
    else $error("charge off during burst");
  a_miso_idle: assert property (bus_idle |-> !spi_miso_oe)
    else $error("data out driven while deselected");
  a_miso_driven: assert property (!spi_cs_n [*6] |-> spi_miso_oe)
    else $error("data out not driven while selected");
endmodule // bdcs_properties
bind burst_drive_control_status bdcs_properties bdcs_properties_i (.clock, .resetn, .spi_cs_n, .spi_miso_oe,
  .paired_side_drive_select, .pre_driver_enable, .pulse_count, .sleep_active, .standby_active, .burst_active,
  .charge_enable, .regulation_enable);
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench of the burst drive register slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb_top;
  logic clock, resetn, burst_pin_1, burst_pin_2, drive_pulse_in, supply_at_level, nvm_check_failed;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, paired_side_drive_select, pre_driver_enable;
  wire sleep_active, standby_active, burst_active, charge_enable, regulation_enable;
  wire [5:0] pulse_count;
  int n_errors = 0;
  int n_compared = 0;
  logic [7:0] mdl[int] = '{'h1a:0, 'h1b:0, 'h1c:0, 'h1d:'h5a, 'h1e:'h01, 'h16:'h20, 'h14:0};
  logic [7:0] msk[int] = '{'h1a:'hff, 'h1b:'hc3, 'h16:'h7f, 'h14:'h1f};
  burst_drive_control_status burst_drive_control_status_i (.clock, .resetn, .spi_sclk, .spi_cs_n, .spi_mosi,
    .spi_miso, .spi_miso_oe, .burst_pin_1, .burst_pin_2, .drive_pulse_in, .supply_at_level, .nvm_check_failed,
    .paired_side_drive_select, .pre_driver_enable, .pulse_count, .sleep_active, .standby_active, .burst_active,
    .charge_enable, .regulation_enable);
  spi_ctrl_model spi_ctrl_model_i (.clock, .sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));
  // ==========================================
  // Bus tasks and reference checks
  task automatic wr(input int a, input int d);
    logic [7:0] r;
    spi_ctrl_model_i.xfer({1'b0, a[6:0], d[7:0]}, r);
    if (msk.exists(a)) mdl[a] = d[7:0] & msk[a];
  endtask
  task automatic rdchk(input int a);
    logic [7:0] r, e;
    spi_ctrl_model_i.xfer({1'b1, a[6:0], 8'h00}, r);
    e = mdl.exists(a) ? mdl[a] : 8'h00;
    if (a == 'h1c) begin
      r = r & 8'h09;
      e = {4'h0, supply_at_level, 2'b00, nvm_check_failed};
    end
    `CHK("read", e, r)
  endtask
  task automatic outs;
    repeat (3) @(posedge clock);
    `CHK("drive", {paired_side_drive_select, pre_driver_enable, pulse_count}, mdl['h1a])
    `CHK("power", {sleep_active, standby_active}, mdl['h1b][7:6])
  endtask
  task automatic bchk;
    logic eb;
    logic [7:0] t;
    t = mdl['h1b];
    repeat (4) @(posedge clock);
    case (mdl['h14][1:0])
      2'd0: eb = t[0];
      2'd2: eb = burst_pin_1 != burst_pin_2;
      default: eb = !burst_pin_1;
    endcase
    eb = eb && !t[7];
    `CHK("burst", eb, burst_active)
    `CHK("charge", !mdl['h16][5] && (eb || !mdl['h16][6] || t[1]), charge_enable)
    `CHK("regulation", !mdl['h16][5], regulation_enable)
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Clock, watchdog and test sequence
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    give_verdict();
  end
  initial begin
    resetn = 1'b0;
    {burst_pin_1, burst_pin_2, drive_pulse_in, supply_at_level, nvm_check_failed} = 5'b11000;
    void'($urandom(55830));
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    foreach (mdl[a]) rdchk(a);
    rdchk('h40);
    $display("test reset values done");
    for (int k = 0; k < 6; k++) begin
      wr('h1a, $urandom);
      wr('h1b, $urandom & 'hfe);
      outs();
      rdchk('h1a);
      rdchk('h1b);
    end
    $display("test config done");
    for (int a = 'h1c; a <= 'h1e; a++) begin
      wr(a, $urandom);
      rdchk(a);
    end
    wr('h40, 'h5a);
    rdchk('h40);
    for (int s = 0; s < 4; s++) begin
      {supply_at_level, nvm_check_failed} <= s[1:0];
      rdchk('h1c);
    end
    $display("test read-only done");
    wr('h1a, 0);
    for (int c = 0; c < 4; c++) begin
      wr('h16, c << 5);
      for (int m = 0; m < 4; m++) begin
        wr('h14, m);
        for (int t = 0; t < 8; t++) begin
          {burst_pin_1, burst_pin_2, drive_pulse_in} <= 3'($urandom);
          wr('h1b, (t & 3) | ((t & 4) << 5));
          bchk();
        end
      end
    end
    $display("test burst and charge done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
